// ==== shared/sacr_map.svh ====
// register map, field positions, reset value and timing counts
`ifndef SACR_MAP_SVH
`define SACR_MAP_SVH

// byte offsets on the register port
`define SACR_OFS_IRQ_EN2    8'h9a
`define SACR_OFS_P0_CFG     8'h9e
`define SACR_OFS_IRQ_REQ2   8'hbf
`define SACR_OFS_MODE       8'hd2
`define SACR_OFS_RES_HI     8'hd3
`define SACR_OFS_RES_LO     8'hd4
`define SACR_OFS_REF_SEL    8'hd5

// mode register fields
`define SACR_MODE_EN_BIT    7
`define SACR_MODE_START_BIT 6
`define SACR_MODE_EOC_BIT   5

// result-low/config register fields
`define SACR_LO_GATE_BIT    6
`define SACR_LO_CKS_MSB     5
`define SACR_LO_CKS_LSB     4

// converter clock select codes
`define SACR_CKS_DIV16      2'h0
`define SACR_CKS_DIV8       2'h1
`define SACR_CKS_DIV1       2'h2
`define SACR_CKS_DIV2       2'h3

// last divider count for each code
`define SACR_DIV16_LAST     4'hf
`define SACR_DIV8_LAST      4'h7
`define SACR_DIV1_LAST      4'h0
`define SACR_DIV2_LAST      4'h1

// channel codes
`define SACR_CHS_LAST_EXT   4'h5
`define SACR_CHS_INTERNAL   4'h8

// conversion span: 16 periods of the converter clock divided by 4
`define SACR_CONV_PERIODS   16
`define SACR_CONV_PRESCALE  4
`define SACR_CONV_TICKS     (`SACR_CONV_PERIODS * `SACR_CONV_PRESCALE)
`define SACR_CONV_LAST      6'(`SACR_CONV_TICKS - 1)

// every state bit clears on reset
`define SACR_STATE_RST      '0

`endif

// ==== shared/sacr_pkg.sv ====
// types shared by the converter control block
package sacr_pkg;

    // conversion sequencer, gray along idle -> convert
    typedef enum logic [1:0] {
        SACR_IDLE = 2'b00,
        SACR_CONV = 2'b01
    } sacr_fsm_e;

    // divider state
    typedef struct packed {
        logic [3:0] cnt;
    } sacr_div_s;

    // state of the control block apart from the divider count
    typedef struct packed {
        sacr_fsm_e   fsm;
        logic        enable;
        logic        start;
        logic        eoc;
        logic [3:0]  input_channel_select;
        logic        gate;
        logic [1:0]  cks;
        logic [11:0] result;
        logic [2:0]  reference_level_field;
        logic [5:0]  port0_pure_analog_bits;
        logic        irq_en;
        logic        irq_flag;
        logic [5:0]  tick_cnt;
        logic [7:0]  rdata;
        logic [5:0]  sync1;
        logic [5:0]  sync2;
        logic [5:0]  sync3;
        logic [5:0]  din;
        logic        irq;
        logic [5:0]  ain_sel;
        logic        int_sel;
        logic        ref_supply;
        logic [1:0]  int_level;
        logic        ref_ok;
        logic        run;
        logic        tick;
    } sacr_state_s;

endpackage : sacr_pkg

// ==== shared/sacr_div_if.sv ====
// link between the sequencer and the converter clock divider
`timescale 1ns/1ps
interface sacr_div_if;
    logic       ce;   // clock enable
    logic       run;  // divider counts while high
    logic [1:0] sel;  // clock select code
    logic       tick; // one converter clock period elapsed

    modport ctl (output ce, output run, output sel, input tick);
    modport div (input ce, input run, input sel, output tick);
endinterface : sacr_div_if

// ==== logic/sacr_clkdiv.sv ====
// converter clock divider, one tick per converter clock period
`timescale 1ns/1ps
`include "sacr_map.svh"
module sacr_clkdiv (
    input  wire logic rst_n_i,
    input  wire logic ref_clk_i,
    sacr_div_if.div   dv
);
    import sacr_pkg::*;

    sacr_div_s  st_r;   // registered state
    sacr_div_s  st_nxt; // next state
    logic [3:0] lim;    // last count of the selected division

    // division limit per select code
    function automatic logic [3:0] sacr_div_last(input logic [1:0] sel);
        case (sel)
            `SACR_CKS_DIV16: sacr_div_last = `SACR_DIV16_LAST;
            `SACR_CKS_DIV8:  sacr_div_last = `SACR_DIV8_LAST;
            `SACR_CKS_DIV1:  sacr_div_last = `SACR_DIV1_LAST;
            default:         sacr_div_last = `SACR_DIV2_LAST;
        endcase
    endfunction : sacr_div_last

    // tick on the last count; divider restarts whenever run drops
    // a count already past a newly lowered limit ticks at once, never wraps
    always_comb begin
        lim     = sacr_div_last(dv.sel);
        dv.tick = dv.run && (st_r.cnt >= lim);
        st_nxt  = st_r;
        if (dv.ce) begin
            if (!dv.run || dv.tick) begin
                st_nxt.cnt = 4'h0;
            end else begin
                st_nxt.cnt = st_r.cnt + 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= `SACR_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // count stays within the selected division
    property p_div_range;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (dv.run && dv.ce) |=> (st_r.cnt <= $past(lim));
    endproperty
    a_div_range: assert property (p_div_range)
        else $error("divider count beyond selected division");

endmodule : sacr_clkdiv

// ==== logic/sacr_top.sv ====
// control and status registers of the 12-bit successive-approximation converter
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "sacr_map.svh"
module sacr_top (
    input  wire logic        ref_clk_i,       // oscillator clock
    input  wire logic        rst_n_i,         // asynchronous system reset
    input  wire logic        clk_en_i,        // freezes all state while low
    input  wire logic [7:0]  reg_addr_i,      // register offset
    input  wire logic [7:0]  reg_wdata_i,     // write data
    input  wire logic        reg_wr_i,        // write strobe
    input  wire logic        reg_rd_i,        // read strobe
    output logic      [7:0]  reg_rdata_o,     // read data, cycle after strobe
    input  wire logic [11:0] conv_data_i,     // code from the analog core
    input  wire logic        irq_ack_i,       // processor enters service
    input  wire logic [5:0]  port0_pin_i,     // raw port 0 pin levels
    output logic      [5:0]  port0_din_o,     // digital input path
    output logic             irq_o,           // converter interrupt
    output logic      [5:0]  ain_sel_o,       // external input switches
    output logic             int_sel_o,       // internal level channel switch
    output logic             ref_supply_o,    // supply as high reference
    output logic      [1:0]  int_level_o,     // 0:2V 1:3V 2:4V
    output logic             ref_ok_o,        // reference code not reserved
    output logic             conv_run_o,      // analog core converting
    output logic             conv_tick_o      // converter clock period pulse
);
    import sacr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    sacr_state_s st_r;     // registered state
    sacr_state_s st_nxt;   // next state
    sacr_div_if  dv ();    // divider link
    logic        wr_mode;  // write to mode register
    logic        wr_lo;    // write to result-low/config
    logic        wr_ref;   // write to reference select
    logic        wr_p0;    // write to port 0 analog config
    logic        wr_ien;   // write to interrupt enable two
    logic        wr_irq;   // write to interrupt request two
    logic        go;       // accepted start request
    logic        done;     // last converter period of a conversion
    logic [6:0]  ch_dec;   // decoded channel switches
    logic [3:0]  ref_dec;  // decoded reference
    logic [6:0]  hp_ticks; // helper for the span check

    ////////////////////////////////////////////////////////////////////////
    // decode functions

    // {internal, external[5:0]} switches; none unless gated
    function automatic logic [6:0] sacr_chan(input logic [3:0] input_channel_select,
                                             input logic       gate);
        sacr_chan = 7'h00;
        if (gate) begin
            if (input_channel_select <= `SACR_CHS_LAST_EXT) begin
                sacr_chan[input_channel_select[2:0]] = 1'b1;
            end else if (input_channel_select == `SACR_CHS_INTERNAL) begin
                sacr_chan[6] = 1'b1;
            end
        end
    endfunction : sacr_chan

    // {valid, supply, level[1:0]} from the reference field
    function automatic logic [3:0] sacr_ref(input logic [2:0] reference_level_field);
        case (reference_level_field)
            3'h0:    sacr_ref = 4'h8; // internal 2V
            3'h1:    sacr_ref = 4'h9; // internal 3V
            3'h2:    sacr_ref = 4'ha; // internal 4V
            3'h4:    sacr_ref = 4'he; // supply, internal channel 4V
            3'h5:    sacr_ref = 4'hd; // supply, internal channel 3V
            3'h6:    sacr_ref = 4'hc; // supply, internal channel 2V
            default: sacr_ref = 4'h0; // reserved
        endcase
    endfunction : sacr_ref

    ////////////////////////////////////////////////////////////////////////
    // converter clock divider

    assign dv.ce  = clk_en_i;
    assign dv.run = (st_r.fsm == SACR_CONV);
    assign dv.sel = st_r.cks;

    sacr_clkdiv u_div (
        .rst_n_i   (rst_n_i),
        .ref_clk_i (ref_clk_i),
        .dv        (dv.div)
    );

    ////////////////////////////////////////////////////////////////////////
    // strobes and sequencer conditions

    // address decode of the write strobe
    always_comb begin
        wr_mode = reg_wr_i && (reg_addr_i == `SACR_OFS_MODE);
        wr_lo   = reg_wr_i && (reg_addr_i == `SACR_OFS_RES_LO);
        wr_ref  = reg_wr_i && (reg_addr_i == `SACR_OFS_REF_SEL);
        wr_p0   = reg_wr_i && (reg_addr_i == `SACR_OFS_P0_CFG);
        wr_ien  = reg_wr_i && (reg_addr_i == `SACR_OFS_IRQ_EN2);
        wr_irq  = reg_wr_i && (reg_addr_i == `SACR_OFS_IRQ_REQ2);
        // start needs the enable bit in the same write
        go      = wr_mode && reg_wdata_i[`SACR_MODE_START_BIT]
                  && reg_wdata_i[`SACR_MODE_EN_BIT];
        done    = (st_r.fsm == SACR_CONV) && dv.tick
                  && (st_r.tick_cnt == `SACR_CONV_LAST);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;
        if (clk_en_i) begin
            // software writes; result bits have no write path
            if (wr_mode) begin
                st_nxt.enable = reg_wdata_i[`SACR_MODE_EN_BIT];
                st_nxt.input_channel_select    = reg_wdata_i[3:0];
                if (!reg_wdata_i[`SACR_MODE_EOC_BIT]) begin
                    st_nxt.eoc = 1'b0;
                end
            end
            if (wr_lo) begin
                st_nxt.gate = reg_wdata_i[`SACR_LO_GATE_BIT];
                st_nxt.cks  = reg_wdata_i[`SACR_LO_CKS_MSB:`SACR_LO_CKS_LSB];
            end
            if (wr_ref) begin
                st_nxt.reference_level_field = reg_wdata_i[2:0];
            end
            if (wr_p0) begin
                st_nxt.port0_pure_analog_bits = reg_wdata_i[5:0];
            end
            if (wr_ien) begin
                st_nxt.irq_en = reg_wdata_i[0];
            end
            if (wr_irq) begin
                st_nxt.irq_flag = reg_wdata_i[0];
            end
            // entering service clears the request
            if (irq_ack_i) begin
                st_nxt.irq_flag = 1'b0;
            end

            // conversion sequencer
            case (st_r.fsm)
                SACR_IDLE: begin
                    st_nxt.start = 1'b0;
                    if (go) begin
                        st_nxt.fsm      = SACR_CONV;
                        st_nxt.start    = 1'b1;
                        st_nxt.eoc      = 1'b0;
                        st_nxt.tick_cnt = 6'h00;
                    end
                end
                SACR_CONV: begin
                    // further start writes are ignored here
                    if (!st_nxt.enable) begin
                        // disable aborts without any completion flag
                        st_nxt.fsm      = SACR_IDLE;
                        st_nxt.start    = 1'b0;
                        st_nxt.tick_cnt = 6'h00;
                    end else if (done) begin
                        // set wins over a clear in the same cycle
                        st_nxt.fsm      = SACR_IDLE;
                        st_nxt.start    = 1'b0;
                        st_nxt.eoc      = 1'b1;
                        st_nxt.irq_flag = 1'b1;
                        st_nxt.result   = conv_data_i;
                        st_nxt.tick_cnt = 6'h00;
                    end else if (dv.tick) begin
                        st_nxt.tick_cnt = st_r.tick_cnt + 6'h01;
                    end
                end
                default: begin
                    st_nxt.fsm   = SACR_IDLE;
                    st_nxt.start = 1'b0;
                end
            endcase

            // pin synchroniser; a change counts once stages two and three agree
            st_nxt.sync1 = port0_pin_i;
            st_nxt.sync2 = st_r.sync1;
            st_nxt.sync3 = st_r.sync2;
            for (int i = 0; i < 6; i++) begin
                if (st_r.port0_pure_analog_bits[i]) begin
                    st_nxt.din[i] = 1'b0;
                end else if (st_r.sync2[i] == st_r.sync3[i]) begin
                    st_nxt.din[i] = st_r.sync3[i];
                end
            end

            // analog side controls follow the new register values
            ch_dec = sacr_chan(st_nxt.input_channel_select, st_nxt.gate);
            ref_dec = sacr_ref(st_nxt.reference_level_field);
            st_nxt.ain_sel    = ch_dec[5:0];
            st_nxt.int_sel    = ch_dec[6];
            st_nxt.ref_ok     = ref_dec[3];
            st_nxt.ref_supply = ref_dec[2];
            st_nxt.int_level  = ref_dec[1:0];
            st_nxt.irq        = st_nxt.irq_flag && st_nxt.irq_en;
            st_nxt.run        = (st_nxt.fsm == SACR_CONV);
            st_nxt.tick       = (st_r.fsm == SACR_CONV) && dv.tick;

            // read data stand only in the cycle after the strobe
            st_nxt.rdata = 8'h00;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `SACR_OFS_MODE:    st_nxt.rdata = {st_r.enable, st_r.start,
                                                       st_r.eoc, 1'b0, st_r.input_channel_select};
                    `SACR_OFS_RES_HI:  st_nxt.rdata = st_r.result[11:4];
                    `SACR_OFS_RES_LO:  st_nxt.rdata = {1'b0, st_r.gate, st_r.cks,
                                                       st_r.result[3:0]};
                    `SACR_OFS_REF_SEL: st_nxt.rdata = {5'h00, st_r.reference_level_field};
                    `SACR_OFS_P0_CFG:  st_nxt.rdata = {2'h0, st_r.port0_pure_analog_bits};
                    `SACR_OFS_IRQ_EN2: st_nxt.rdata = {7'h00, st_r.irq_en};
                    `SACR_OFS_IRQ_REQ2: st_nxt.rdata = {7'h00, st_r.irq_flag};
                    default:           st_nxt.rdata = 8'h00;
                endcase
            end
        end else begin
            ch_dec  = 7'h00;
            ref_dec = 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register and outputs

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= `SACR_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // every output is a state bit
    assign reg_rdata_o  = st_r.rdata;
    assign port0_din_o  = st_r.din;
    assign irq_o        = st_r.irq;
    assign ain_sel_o    = st_r.ain_sel;
    assign int_sel_o    = st_r.int_sel;
    assign ref_supply_o = st_r.ref_supply;
    assign int_level_o  = st_r.int_level;
    assign ref_ok_o     = st_r.ref_ok;
    assign conv_run_o   = st_r.run;
    assign conv_tick_o  = st_r.tick;

    ////////////////////////////////////////////////////////////////////////
    // checks

    // converter periods since the last accepted start
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hp_ticks <= 7'h00;
        end else if (clk_en_i) begin
            if (go && st_r.fsm == SACR_IDLE) begin
                hp_ticks <= 7'h00;
            end else if (dv.tick && st_r.fsm == SACR_CONV) begin
                hp_ticks <= hp_ticks + 7'h01;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_span;
        $rose(st_r.eoc) |-> (hp_ticks == 7'h40);
    endproperty
    a_span: assert property (p_span)
        else $error("conversion span not 64 converter periods");

    property p_div1;
        (dv.run && st_r.cks == `SACR_CKS_DIV1) |-> dv.tick;
    endproperty
    a_div1: assert property (p_div1)
        else $error("undivided clock missed a period");

    property p_result_ro;
        (wr_lo && st_r.fsm == SACR_IDLE) |=> $stable(st_r.result);
    endproperty
    a_result_ro: assert property (p_result_ro)
        else $error("result changed by a write");

    property p_disable;
        (clk_en_i && wr_mode && !reg_wdata_i[`SACR_MODE_EN_BIT])
            |=> (!st_r.start && st_r.fsm == SACR_IDLE && !$rose(st_r.eoc));
    endproperty
    a_disable: assert property (p_disable)
        else $error("disabled converter still converting");

    property p_start_held;
        (st_r.fsm == SACR_CONV) |-> (st_r.start && !st_r.eoc);
    endproperty
    a_start_held: assert property (p_start_held)
        else $error("start or completion bit wrong while converting");

    property p_eoc_sticky;
        (st_r.eoc && !wr_mode) |=> st_r.eoc;
    endproperty
    a_eoc_sticky: assert property (p_eoc_sticky)
        else $error("completion bit dropped without a write");

    property p_complete;
        (clk_en_i && done && st_r.enable && !wr_mode)
            |=> (st_r.eoc && st_r.irq_flag && !st_r.start
                 && st_r.result == $past(conv_data_i));
    endproperty
    a_complete: assert property (p_complete)
        else $error("completion did not load result and flags");

    property p_ack;
        (clk_en_i && irq_ack_i && !done) |=> !st_r.irq_flag;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge did not clear request");

    property p_no_spurious;
        (clk_en_i && st_r.fsm == SACR_IDLE && !go) |=> (st_r.fsm == SACR_IDLE);
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("conversion began without a start write");

    property p_no_restart;
        (clk_en_i && st_r.fsm == SACR_CONV && go && !done)
            |=> (st_r.tick_cnt >= $past(st_r.tick_cnt));
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("start during conversion restarted the count");

    property p_pure_analog;
        clk_en_i |=> ((port0_din_o & $past(st_r.port0_pure_analog_bits)) == 6'h00);
    endproperty
    a_pure_analog: assert property (p_pure_analog)
        else $error("digital input passed on a pure analog pin");

    property p_irq_gate;
        irq_o |-> (st_r.irq_en && st_r.irq_flag);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while disabled");

endmodule : sacr_top

// ==== tb/sacr_analog_model.sv ====
// behavioural model of the port 0 analog inputs and the analog core code
`timescale 1ns/1ps
module sacr_analog_model (
    input  wire logic        ref_clk_i,   // oscillator clock
    input  wire logic [5:0]  ain_sel_i,   // external input switches
    input  wire logic        int_sel_i,   // internal level channel switch
    input  wire logic [1:0]  int_level_i, // internal level code
    input  wire logic [5:0]  pin_level_i, // digital levels wanted on the pins
    output logic      [11:0] conv_data_o, // straight binary code of the input
    output logic      [5:0]  port0_pin_o  // raw pin levels
);
    logic flip_r; // toggles so an open input never looks stable

    ////////////////////////////////////////////////////////////////////////////
    // open input: changing pattern, the simulator must not pick a value
    always_ff @(posedge ref_clk_i) begin
        flip_r <= (flip_r === 1'b1) ? 1'b0 : 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // fixed input on channels 0, 3 and 5 and the internal channel, coded from zero up to full scale
    always_comb begin
        if (int_sel_i === 1'b1) begin
            conv_data_o = {int_level_i, 10'h3c7};
        end else if (ain_sel_i === 6'h01) begin
            conv_data_o = 12'h000;
        end else if (ain_sel_i === 6'h20) begin
            conv_data_o = 12'hfff;
        end else if (ain_sel_i === 6'h08) begin
            conv_data_o = 12'h5a3;
        end else begin
            conv_data_o = flip_r ? 12'h555 : 12'haaa;
        end
    end

    assign port0_pin_o = pin_level_i; // pins follow the wanted levels
endmodule : sacr_analog_model

// ==== tb/tb.sv ====
// self-checking bench of the converter control registers
`timescale 1ns/1ps
`include "sacr_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    typedef struct { logic [7:0] a; logic [7:0] w; logic [7:0] e; } sacr_row_s;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, ack = 0, ce = 1, irq, run, tick, ok, sup, isel;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, got;
    logic [11:0] cdata;
    logic [5:0]  pins, plev = 6'h2a, din, asel;
    logic [1:0]  lvl;
    int          failures = 0, comparisons = 0, runs = 0, ticks = 0;
    sacr_row_s   rows[8] = '{'{8'h9e, 8'hff, 8'h3f}, '{8'h9a, 8'hff, 8'h01},
        '{8'hbf, 8'hff, 8'h01}, '{8'hd5, 8'hff, 8'h07}, '{8'hd3, 8'hff, 8'h00},
        '{8'hd4, 8'h8f, 8'h00}, '{8'hd2, 8'h1f, 8'h0f}, '{8'h00, 8'hff, 8'h00}};
    logic [7:0]  input_channel_select[4] = '{8'h00, 8'h05, 8'h03, 8'h08}; // channel per clock code
    int          divs[4] = '{16, 8, 1, 2};                  // divider per clock code
    logic [11:0] codes[4] = '{12'h000, 12'hfff, 12'h5a3, 12'hbc7};
    logic [31:0] reftab = 32'h0cde0a98; // {ok, supply, level} per reference code

    sacr_top DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .conv_data_i(cdata), .irq_ack_i(ack), .port0_pin_i(pins), .port0_din_o(din),
        .irq_o(irq), .ain_sel_o(asel), .int_sel_o(isel), .ref_supply_o(sup),
        .int_level_o(lvl), .ref_ok_o(ok), .conv_run_o(run), .conv_tick_o(tick));
    sacr_analog_model far (.ref_clk_i(clk), .ain_sel_i(asel), .int_sel_i(isel),
        .int_level_i(lvl), .pin_level_i(plev), .conv_data_o(cdata), .port0_pin_o(pins));

    initial begin // 40 MHz oscillator
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin // cycles spent converting, converter periods seen
        if (run === 1'b1) runs <= runs + 1;
        if (tick === 1'b1) ticks <= ticks + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port cycles: one strobe cycle each, data the cycle after
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1; // let the written state settle before the caller looks
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg
    task automatic end_sim;
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    initial begin // hang guard, far above the 2000-odd cycles the run needs
        #500000;
        failures++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin // write then read back each register
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a);
            `CHK("readback", rows[i].e, got)
        end
        `CHK("irq on", 1'b1, irq)
        for (int v = 0; v < 8; v++) begin // every reference code
            wr_reg(8'hd5, 8'(v));
            @(posedge clk); #1;
            `CHK("ref", reftab[4*v +: 4], {ok, sup, lvl})
        end
        wr_reg(8'h9a, 8'h00);
        `CHK("irq masked", 1'b0, irq)
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin // every clock code, a conversion each
            if (input_channel_select[c] == 8'h08) wr_reg(8'hd5, 8'h04);
            wr_reg(8'h9a, 8'h01); wr_reg(8'hbf, 8'h00);
            wr_reg(8'hd4, 8'h40 | 8'(c << 4));
            wr_reg(8'hd2, 8'h80 | input_channel_select[c]);
            `CHK("switch", (input_channel_select[c] == 8'h08) ? 7'h40 : 7'(1 << input_channel_select[c]), {isel, asel})
            runs = 0;
            ticks = 0;
            wr_reg(8'hd2, 8'hc0 | input_channel_select[c]);
            wr_reg(8'hd2, 8'hc0 | input_channel_select[c]); // second start must not restart
            for (int k = 0; k < 1100 && run === 1'b1; k++) @(posedge clk);
            #1 `CHK("conv cycles", 64 * divs[c], runs)
            `CHK("ticks", 64, ticks)
            `CHK("irq end", 1'b1, irq)
            rd_reg(8'hd3); `CHK("res hi", codes[c][11:4], got)
            rd_reg(8'hd4); `CHK("res lo", {2'h1, 2'(c), codes[c][3:0]}, got)
            rd_reg(8'hd2); `CHK("mode end", 8'ha0 | input_channel_select[c], got)
            @(posedge clk) ack <= 1'b1;
            @(posedge clk) ack <= 1'b0;
            rd_reg(8'hbf); `CHK("ack clears", 8'h00, got)
        end
        $display("test conversions done");
        wr_reg(8'hd4, 8'h20); // gate off, undivided clock
        `CHK("gate off", 7'h00, {isel, asel})
        wr_reg(8'hd2, 8'h40); // start while disabled
        @(posedge clk); #1 `CHK("no start", 1'b0, run)
        wr_reg(8'hd2, 8'hc0); repeat (5) @(posedge clk);
        wr_reg(8'hd2, 8'h00); // disable mid-conversion
        @(posedge clk); #1 `CHK("abort", 1'b0, run)
        rd_reg(8'hd2); `CHK("abort mode", 8'h00, got)
        rd_reg(8'hbf); `CHK("abort flag", 8'h00, got)
        rd_reg(8'hd3); `CHK("abort result", codes[3][11:4], got)
        $display("test aborts done");
        wr_reg(8'h9e, 8'h00); repeat (6) @(posedge clk);
        #1 `CHK("din", 6'h2a, din)
        wr_reg(8'h9e, 8'h0f); repeat (2) @(posedge clk);
        #1 `CHK("din cut", 6'h20, din)
        @(posedge clk) plev <= 6'h15; // pins change; bits 3:0 stay cut
        repeat (3) @(posedge clk);
        #1 `CHK("din hold", 6'h20, din)
        @(posedge clk);
        #1 `CHK("din new", 6'h10, din)
        @(posedge clk) ce <= 1'b0; // frozen: the write below is lost
        wr_reg(8'h9a, 8'h00);
        @(posedge clk) ce <= 1'b1;
        rd_reg(8'h9a); `CHK("frozen", 8'h01, got)
        $display("test pins done");
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk) rst_n <= 1'b1;
        foreach (rows[i]) begin // reset values, result high byte and low nibble left out
            rd_reg(rows[i].a);
            if (rows[i].a != 8'hd3) `CHK("reset", 8'h00, got & ~8'(rows[i].a == 8'hd4 ? 15 : 0))
        end
        $display("test reset done");
        end_sim();
    end
endmodule : tb
